// ### common/gei_pkg.sv
// How it works
// - written data bit drives its pin while that pin is an output
// - port data reads return synchronised pin levels, not stored data
// - direction one makes the pin an output; zero turns its driver off
// - drive-low bit one: serial output driven low in whole second word
// - drive-low bit zero: serial output high impedance in second word
// - pin rise enables let a low-to-high pin change set its status
// - pin fall enables let a high-to-low pin change set its status
// - bit 11 enables gate converter-ready edges into its status
// - bit 12 enables gate positive-X plate edges into its status
// - bit 13 enables gate negative-X plate edges into its status
// - bit 14 enables gate telecom overload edges into its status
// - bit 15 enables gate audio overload edges into its status
// - status address bits 0 to 9 read back the pin statuses
// - pin status clears only on a zero-to-one step versus last write
// - bit 11 reads converter-ready status; zero-to-one write clears it
// - bit 12 reads positive-X status; zero-to-one write clears it
// - bit 13 reads negative-X status; zero-to-one write clears it
// - bits 14, 15 read overload statuses; zero-to-one write clears them
package gei_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [3:0]  REG_PORT_DATA   = 4'h0;
    localparam logic [3:0]  REG_PORT_DIR    = 4'h1;
    localparam logic [3:0]  REG_RISE_EN     = 4'h2;
    localparam logic [3:0]  REG_FALL_EN     = 4'h3;
    localparam logic [3:0]  REG_IRQ_CLR_STAT = 4'h4;

    localparam logic [15:0] RESET_VALUE     = 16'h0000;
    localparam logic [15:0] PIN_MASK        = 16'h03FF;
    localparam logic [15:0] DIR_MASK        = 16'h83FF;
    localparam logic [15:0] IRQ_MASK        = 16'hFBFF;
    localparam int          DRIVE_LOW_BIT   = 15;
    localparam int          NUM_PINS        = 10;
    localparam int          NUM_SRC         = 16;

    // ------------------------------------------------------------------
    // serial frame layout, bit numbers within the 64-bit frame
    // ------------------------------------------------------------------
    localparam logic [5:0]  BIT_ADDR_LAST   = 6'h04;
    localparam logic [5:0]  BIT_HEAD_LAST   = 6'h0F;
    localparam logic [5:0]  BIT_WORD1_LAST  = 6'h1F;
    localparam logic [5:0]  BIT_FRAME_LAST  = 6'h3F;
    localparam logic [5:0]  BIT_AFTER_SYNC  = 6'h01;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_HEAD   = 2'b01,
        PH_DATA   = 2'b10,
        PH_SECOND = 2'b11
    } gei_phase_e;

endpackage

// ### dv/gei_gpio_regs_tb.sv
`timescale 1ns/10ps
module gei_gpio_regs_tb;
    // ----------------------------------------------------------------
    // signals and bookkeeping
    // ----------------------------------------------------------------
    logic        ref_clk;
    logic        rst_n;
    logic [15:0] src;
    logic [9:0]  pin_in;
    logic [9:0]  pin_out;
    logic [9:0]  pin_oe;
    logic        sib_clk;
    logic        sib_sync;
    logic        sib_din;
    logic        serial_out_pin;
    logic        serial_out_oe;
    logic        rd_valid;
    logic [15:0] rd_data;
    logic [1:0]  sw_flags;
    logic [17:0] exp_q[$];
    logic [15:0] dat;
    logic [15:0] dir;
    logic [2:0]  gap;
    logic        dl;
    int          err_total;
    int          num_checks;
    int          seed;

    // a pin set as output shows its own drive, else the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & src[9:0]);

    gei_gpio_regs u_gei_gpio_regs (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .conv_done(src[11]), .touch_plate_pos_x(src[12]),
        .touch_plate_neg_x(src[13]), .tel_overload(src[14]),
        .aud_overload(src[15]), .sib_clk(sib_clk), .sib_sync(sib_sync),
        .sib_din(sib_din), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe));

    gei_sib_host u_gei_sib_host (.ref_clk(ref_clk), .sib_clk(sib_clk),
        .sib_sync(sib_sync), .sib_din(sib_din),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .rd_valid(rd_valid), .rd_data(rd_data), .sw_flags(sw_flags));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        gap = 3'($random(seed));
        u_gei_sib_host.frame(1'b1, a, d, gap);
    endtask

    // second word flags expected: both set when driven low, both clear
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        gap = 3'($random(seed));
        exp_q.push_back({dl, dl, e});
        u_gei_sib_host.frame(1'b0, a, 16'($random(seed)), gap);
    endtask

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog, result monitor
    // ----------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        chk(32'h00000000, 32'h00000001);
        end_of_test();
    end

    initial
    begin
        forever
        begin
            @(posedge ref_clk);
            if (rd_valid === 1'b1 && exp_q.size() > 0)
                chk({14'h0000, sw_flags, rd_data}, 32'(exp_q.pop_front()));
            else if (rd_valid === 1'b1)
                chk(32'h0000DEAD, 32'h00000000);
        end
    end

    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    initial
    begin
        seed = 32'hdbb4;
        rst_n = 1'b0;
        src = 16'h0000;
        dl = 1'b0;
        err_total = 0;
        num_checks = 0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int a = 0; a < 6; a++)
            rd(4'(a), 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            dat = 16'($random(seed));
            dir = {k[0], 15'($random(seed))};
            src <= 16'($random(seed));
            wr(gei_pkg::REG_PORT_DATA, dat);
            wr(gei_pkg::REG_PORT_DIR, dir);
            dl = dir[15];
            chk({pin_oe, pin_out}, {dir[9:0], dat[9:0]});
            rd(gei_pkg::REG_PORT_DATA, {6'h00, pin_in});
            rd(gei_pkg::REG_PORT_DIR, dir & gei_pkg::DIR_MASK);
        end
        wr(gei_pkg::REG_PORT_DIR, 16'h0000);
        dl = 1'b0;
        src <= 16'h0000;
        wr(gei_pkg::REG_RISE_EN, 16'hFFFF);
        wr(gei_pkg::REG_FALL_EN, 16'h0000);
        wr(gei_pkg::REG_IRQ_CLR_STAT, 16'h0000);
        wr(gei_pkg::REG_IRQ_CLR_STAT, 16'hFFFF);
        src <= 16'hFFFF;
        rd(gei_pkg::REG_IRQ_CLR_STAT, gei_pkg::IRQ_MASK);
        src <= 16'h0000;
        rd(gei_pkg::REG_IRQ_CLR_STAT, gei_pkg::IRQ_MASK);
        wr(gei_pkg::REG_IRQ_CLR_STAT, 16'h0000);
        wr(gei_pkg::REG_IRQ_CLR_STAT, 16'hFFFF);
        rd(gei_pkg::REG_IRQ_CLR_STAT, 16'h0000);
        wr(gei_pkg::REG_RISE_EN, 16'h0000);
        wr(gei_pkg::REG_FALL_EN, 16'hFFFF);
        // unmapped: a decoder that drops the top bit would clear fall enables
        wr(4'hB, 16'h0000);
        rd(gei_pkg::REG_FALL_EN, gei_pkg::IRQ_MASK);
        src <= 16'hFFFF;
        rd(gei_pkg::REG_IRQ_CLR_STAT, 16'h0000);
        src <= 16'h0000;
        rd(gei_pkg::REG_IRQ_CLR_STAT, gei_pkg::IRQ_MASK);
        wr(gei_pkg::REG_IRQ_CLR_STAT, 16'hFFFF);
        rd(gei_pkg::REG_IRQ_CLR_STAT, gei_pkg::IRQ_MASK);
        wr(gei_pkg::REG_IRQ_CLR_STAT, 16'h0000);
        wr(gei_pkg::REG_IRQ_CLR_STAT, 16'h9001);
        rd(gei_pkg::REG_IRQ_CLR_STAT, 16'h6BFE);
        wr(gei_pkg::REG_IRQ_CLR_STAT, 16'h2000);
        rd(gei_pkg::REG_IRQ_CLR_STAT, 16'h4BFE);
        repeat (10) @(posedge ref_clk);
        chk(exp_q.size(), 32'h00000000);
        end_of_test();
    end
endmodule

// ### dv/gei_sib_host.sv
`timescale 1ns/10ps
module gei_sib_host (
    // clock
    input  wire logic        ref_clk,
    // serial bus towards the device
    output logic             sib_clk,
    output logic             sib_sync,
    output logic             sib_din,
    input  wire logic        serial_out_pin,
    input  wire logic        serial_out_oe,
    // captured read results
    output logic             rd_valid,
    output logic      [15:0] rd_data,
    output logic      [1:0]  sw_flags
);
    // ----------------------------------------------------------------
    // frame engine
    // ----------------------------------------------------------------
    initial
    begin
        sib_clk = 1'b0;
        sib_sync = 1'b0;
        sib_din = 1'b0;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
        sw_flags = 2'h0;
    end

    // serial clock stands low between frames; a released output line is
    // seen as the inverse of the last bit so a float never reads right
    task automatic frame(input logic wr, input logic [3:0] adr,
                         input logic [15:0] wd, input logic [2:0] gap);
        logic [63:0] f;
        logic [15:0] rd;
        logic        ok;
        logic        any;
        logic        d;
        f = {wr, adr, 11'h000, wd, 32'h00000000};
        rd = 16'h0000;
        ok = 1'b1;
        any = 1'b0;
        repeat (gap) @(posedge ref_clk);
        for (int i = 0; i < 64; i++)
        begin
            sib_clk <= 1'b1;
            sib_sync <= (i == 0);
            sib_din <= f[63-i];
            repeat (4) @(posedge ref_clk);
            sib_clk <= 1'b0;
            repeat (3) @(posedge ref_clk);
            @(negedge ref_clk);
            d = serial_out_oe ? serial_out_pin : ~rd[0];
            if (i >= 16 && i < 32)
                rd = {rd[14:0], d};
            if (i >= 32)
            begin
                ok = ok & serial_out_oe & ~d;
                any = any | serial_out_oe;
            end
            @(posedge ref_clk);
        end
        if (!wr)
        begin
            rd_data <= rd;
            sw_flags <= {ok, any};
            rd_valid <= 1'b1;
            @(posedge ref_clk);
            rd_valid <= 1'b0;
        end
    endtask
endmodule

// ### hw/gei_edge_irq.sv
`timescale 1ns/10ps
module gei_edge_irq #(
    parameter int          N    = 16,
    parameter logic [15:0] MASK = 16'hFBFF
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // sources and controls
    input  wire logic [N-1:0] src,
    input  wire logic [N-1:0] rise_en,
    input  wire logic [N-1:0] fall_en,
    input  wire logic [N-1:0] clr,
    // sticky status
    output logic      [N-1:0] status
);

    logic [N-1:0] src_prev;
    logic [N-1:0] set_ev;
    logic [N-1:0] next_status;

    default clocking edge_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // edge detect and sticky flags
    // ------------------------------------------------------------------
    always_comb
    begin
        // edges against the registered copy
        set_ev = ((src & ~src_prev & rise_en)
                 | (~src & src_prev & fall_en))
                 & MASK[N-1:0];
        // a set in the clearing cycle wins
        next_status = (status & ~clr) | set_ev;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_prev <= '0;
            status   <= '0;
        end
        else
        begin
            src_prev <= src;
            status   <= next_status;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_rise_sets: assert property (
        ((src & ~src_prev & rise_en & MASK[N-1:0]) != '0)
        |=> ((status & $past(src & ~src_prev & rise_en & MASK[N-1:0]))
             == $past(src & ~src_prev & rise_en & MASK[N-1:0])))
        else $error("enabled rising edge did not set status");

    a_fall_sets: assert property (
        ((~src & src_prev & fall_en & MASK[N-1:0]) != '0)
        |=> ((status & $past(~src & src_prev & fall_en & MASK[N-1:0]))
             == $past(~src & src_prev & fall_en & MASK[N-1:0])))
        else $error("enabled falling edge did not set status");

    a_stat_sticky: assert property (
        ((status & ~clr) != '0)
        |=> ((status & $past(status & ~clr)) == $past(status & ~clr)))
        else $error("status bit dropped without a clear");

    a_no_spurious: assert property (
        (src == src_prev) |=> ((status & ~$past(status)) == '0))
        else $error("status set without an edge");

    c_status_set: cover property (@(posedge ref_clk) disable iff (!rst_n)
        (status == '0) ##1 (status != '0));

endmodule

// ### hw/gei_gpio_regs.sv
`timescale 1ns/10ps
module gei_gpio_regs (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // general purpose pins
    input  wire logic [9:0] pin_in,
    output logic      [9:0] pin_out,
    output logic      [9:0] pin_oe,
    // event sources
    input  wire logic       conv_done,
    input  wire logic       touch_plate_pos_x,
    input  wire logic       touch_plate_neg_x,
    input  wire logic       tel_overload,
    input  wire logic       aud_overload,
    // serial interface bus
    input  wire logic       sib_clk,
    input  wire logic       sib_sync,
    input  wire logic       sib_din,
    output logic            serial_out_pin,
    output logic            serial_out_oe
);

    localparam int NSYNC = 18;

    logic [NSYNC-1:0]    in_meta;
    logic [NSYNC-1:0]    in_sync;
    logic                sclk_prev;
    logic                sclk_fall;
    logic                sclk_rise;
    logic                s_clk;
    logic                s_sync;
    logic                s_din;
    logic [9:0]          pin_lvl;
    logic [15:0]         src_lvl;

    gei_pkg::gei_phase_e phase;
    gei_pkg::gei_phase_e next_phase;
    logic [5:0]          bit_cnt;
    logic [5:0]          next_bit_cnt;
    logic                hdr_wr;
    logic                next_hdr_wr;
    logic [3:0]          hdr_addr;
    logic [3:0]          next_hdr_addr;
    logic [15:0]         shift_in;
    logic [15:0]         next_shift_in;
    logic [15:0]         rd_shift;
    logic [15:0]         next_rd_shift;
    logic                next_dout;
    logic                next_doe;
    logic                wr_stb;
    logic                next_wr_stb;
    logic [3:0]          wr_addr;
    logic [3:0]          next_wr_addr;
    logic [15:0]         wr_data;
    logic [15:0]         next_wr_data;

    logic [15:0]         port_pin_data;
    logic [15:0]         port_pin_direction;
    logic [15:0]         rising_edge_enable;
    logic [15:0]         falling_edge_enable;
    logic [15:0]         clr_last;
    logic [15:0]         next_port_pin_data;
    logic [15:0]         next_port_pin_direction;
    logic [15:0]         next_rising_edge_enable;
    logic [15:0]         next_falling_edge_enable;
    logic [15:0]         next_clr_last;
    logic [15:0]         irq_clear;
    logic [15:0]         irq_status;
    logic                second_word_drive_low;

    default clocking regs_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // synchronisers for everything from outside ref_clk
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_meta   <= '0;
            in_sync   <= '0;
            sclk_prev <= 1'b0;
        end
        else
        begin
            in_meta   <= {aud_overload, tel_overload, touch_plate_neg_x,
                          touch_plate_pos_x, conv_done, sib_din, sib_sync,
                          sib_clk, pin_in};
            in_sync   <= in_meta;
            sclk_prev <= in_sync[10];
        end
    end

    assign pin_lvl   = in_sync[9:0];
    assign s_clk     = in_sync[10];
    assign s_sync    = in_sync[11];
    assign s_din     = in_sync[12];
    assign sclk_fall = sclk_prev & ~s_clk;
    assign sclk_rise = ~sclk_prev & s_clk;
    // bit 10 has no source; its enables are masked anyway
    assign src_lvl   = {in_sync[17:13], 1'b0, pin_lvl};

    assign second_word_drive_low = port_pin_direction[gei_pkg::DRIVE_LOW_BIT];

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    function automatic logic [15:0] read_mux(input logic [3:0] addr);
        logic [15:0] r;
        r = 16'h0000;
        unique case (addr)
            gei_pkg::REG_PORT_DATA:    r = {6'h00, pin_lvl};
            gei_pkg::REG_PORT_DIR:     r = port_pin_direction;
            gei_pkg::REG_RISE_EN:      r = rising_edge_enable;
            gei_pkg::REG_FALL_EN:      r = falling_edge_enable;
            // statuses of pins and the five sources
            gei_pkg::REG_IRQ_CLR_STAT: r = irq_status & gei_pkg::IRQ_MASK;
            default:                   r = 16'h0000;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // serial frame: sample on falling edge, drive on rising edge
    // ------------------------------------------------------------------
    always_comb
    begin
        next_phase    = phase;
        next_bit_cnt  = bit_cnt;
        next_hdr_wr   = hdr_wr;
        next_hdr_addr = hdr_addr;
        next_shift_in = shift_in;
        next_rd_shift = rd_shift;
        next_dout     = serial_out_pin;
        next_doe      = serial_out_oe;
        next_wr_stb   = 1'b0;
        next_wr_addr  = wr_addr;
        next_wr_data  = wr_data;
        if (sclk_fall)
        begin
            if (s_sync)
            begin
                // sync restarts the frame even mid-frame
                next_phase   = gei_pkg::PH_HEAD;
                next_bit_cnt = gei_pkg::BIT_AFTER_SYNC;
                next_hdr_wr  = s_din;
            end
            else
            begin
                unique case (phase)
                    gei_pkg::PH_IDLE:
                    begin
                        next_phase = gei_pkg::PH_IDLE;
                    end
                    gei_pkg::PH_HEAD:
                    begin
                        if (bit_cnt <= gei_pkg::BIT_ADDR_LAST)
                            next_hdr_addr = {hdr_addr[2:0], s_din};
                        if (bit_cnt == gei_pkg::BIT_ADDR_LAST)
                            next_rd_shift = read_mux({hdr_addr[2:0], s_din});
                        if (bit_cnt == gei_pkg::BIT_HEAD_LAST)
                            next_phase = gei_pkg::PH_DATA;
                        next_bit_cnt = bit_cnt + 6'h01;
                    end
                    gei_pkg::PH_DATA:
                    begin
                        next_shift_in = {shift_in[14:0], s_din};
                        if (bit_cnt == gei_pkg::BIT_WORD1_LAST)
                        begin
                            next_wr_stb  = hdr_wr;
                            next_wr_addr = hdr_addr;
                            next_wr_data = {shift_in[14:0], s_din};
                            next_phase   = gei_pkg::PH_SECOND;
                        end
                        next_bit_cnt = bit_cnt + 6'h01;
                    end
                    gei_pkg::PH_SECOND:
                    begin
                        if (bit_cnt == gei_pkg::BIT_FRAME_LAST)
                            next_phase = gei_pkg::PH_IDLE;
                        next_bit_cnt = bit_cnt + 6'h01;
                    end
                endcase
            end
        end
        else if (sclk_rise)
        begin
            if (phase == gei_pkg::PH_DATA && !hdr_wr)
            begin
                next_doe      = 1'b1;
                next_dout     = rd_shift[15];
                next_rd_shift = {rd_shift[14:0], 1'b0};
            end
            else if (phase == gei_pkg::PH_SECOND)
            begin
                next_doe  = second_word_drive_low;
                next_dout = 1'b0;
            end
            else
            begin
                next_doe  = 1'b0;
                next_dout = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase          <= gei_pkg::PH_IDLE;
            bit_cnt        <= 6'h00;
            hdr_wr         <= 1'b0;
            hdr_addr       <= 4'h0;
            shift_in       <= 16'h0000;
            rd_shift       <= 16'h0000;
            serial_out_pin <= 1'b0;
            serial_out_oe  <= 1'b0;
            wr_stb         <= 1'b0;
            wr_addr        <= 4'h0;
            wr_data        <= 16'h0000;
        end
        else
        begin
            phase          <= next_phase;
            bit_cnt        <= next_bit_cnt;
            hdr_wr         <= next_hdr_wr;
            hdr_addr       <= next_hdr_addr;
            shift_in       <= next_shift_in;
            rd_shift       <= next_rd_shift;
            serial_out_pin <= next_dout;
            serial_out_oe  <= next_doe;
            wr_stb         <= next_wr_stb;
            wr_addr        <= next_wr_addr;
            wr_data        <= next_wr_data;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_comb
    begin
        next_port_pin_data       = port_pin_data;
        next_port_pin_direction  = port_pin_direction;
        next_rising_edge_enable  = rising_edge_enable;
        next_falling_edge_enable = falling_edge_enable;
        next_clr_last            = clr_last;
        irq_clear                = 16'h0000;
        if (wr_stb)
        begin
            unique case (wr_addr)
                gei_pkg::REG_PORT_DATA:
                    next_port_pin_data = wr_data & gei_pkg::PIN_MASK;
                gei_pkg::REG_PORT_DIR:
                    next_port_pin_direction = wr_data & gei_pkg::DIR_MASK;
                gei_pkg::REG_RISE_EN:
                    next_rising_edge_enable = wr_data & gei_pkg::IRQ_MASK;
                gei_pkg::REG_FALL_EN:
                    next_falling_edge_enable = wr_data & gei_pkg::IRQ_MASK;
                gei_pkg::REG_IRQ_CLR_STAT:
                begin
                    // only a 0 to 1 step against the last write clears
                    irq_clear     = wr_data & ~clr_last & gei_pkg::IRQ_MASK;
                    next_clr_last = wr_data;
                end
                default:
                    next_clr_last = clr_last;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_pin_data       <= gei_pkg::RESET_VALUE;
            port_pin_direction  <= gei_pkg::RESET_VALUE;
            rising_edge_enable  <= gei_pkg::RESET_VALUE;
            falling_edge_enable <= gei_pkg::RESET_VALUE;
            clr_last            <= gei_pkg::RESET_VALUE;
            pin_out             <= 10'h000;
            pin_oe              <= 10'h000;
        end
        else
        begin
            port_pin_data       <= next_port_pin_data;
            port_pin_direction  <= next_port_pin_direction;
            rising_edge_enable  <= next_rising_edge_enable;
            falling_edge_enable <= next_falling_edge_enable;
            clr_last            <= next_clr_last;
            pin_out             <= next_port_pin_data[9:0];
            pin_oe              <= next_port_pin_direction[9:0];
        end
    end

    // ------------------------------------------------------------------
    // edge interrupt unit
    // ------------------------------------------------------------------
    // clears for bits 12, 13 and 11 follow the same path
    gei_edge_irq #(
        .N    (gei_pkg::NUM_SRC),
        .MASK (gei_pkg::IRQ_MASK)
    ) u_gei_edge_irq (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .src     (src_lvl),
        .rise_en (rising_edge_enable),
        .fall_en (falling_edge_enable),
        .clr     (irq_clear),
        .status  (irq_status)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_data_drive: assert property (
        (wr_stb && wr_addr == gei_pkg::REG_PORT_DATA)
        |=> (pin_out == $past(wr_data[9:0])))
        else $error("pin output does not follow written data");

    a_dir_drive: assert property (
        (wr_stb && wr_addr == gei_pkg::REG_PORT_DIR)
        |=> (pin_oe == $past(wr_data[9:0])))
        else $error("pin enable does not follow direction write");

    a_read_pins: assert property (
        (sclk_fall && !s_sync && phase == gei_pkg::PH_HEAD
         && bit_cnt == gei_pkg::BIT_ADDR_LAST
         && {hdr_addr[2:0], s_din} == gei_pkg::REG_PORT_DATA)
        |=> (rd_shift == {6'h00, $past(pin_lvl)}))
        else $error("data read does not return pin levels");

    a_second_low: assert property (
        (sclk_rise && phase == gei_pkg::PH_SECOND && second_word_drive_low)
        |=> (serial_out_oe && !serial_out_pin))
        else $error("second word not driven low");

    a_second_hiz: assert property (
        (sclk_rise && phase == gei_pkg::PH_SECOND && !second_word_drive_low)
        |=> !serial_out_oe)
        else $error("second word not released");

    // a set bit without a 0 to 1 step must survive; new edges may still set
    a_clear_step: assert property (
        (wr_stb && wr_addr == gei_pkg::REG_IRQ_CLR_STAT)
        |=> ((irq_status & $past(irq_status & (~wr_data | clr_last)))
             == $past(irq_status & (~wr_data | clr_last)))
            and (clr_last == $past(wr_data)))
        else $error("clear register misbehaves");

    a_stat_read: assert property (
        (sclk_fall && !s_sync && phase == gei_pkg::PH_HEAD
         && bit_cnt == gei_pkg::BIT_ADDR_LAST
         && {hdr_addr[2:0], s_din} == gei_pkg::REG_IRQ_CLR_STAT)
        |=> (rd_shift == ($past(irq_status) & gei_pkg::IRQ_MASK)))
        else $error("status read mismatch");

    c_write_frame: cover property (@(posedge ref_clk) disable iff (!rst_n)
        wr_stb);
    c_read_frame: cover property (@(posedge ref_clk) disable iff (!rst_n)
        serial_out_oe && phase == gei_pkg::PH_DATA);
    c_second_low: cover property (@(posedge ref_clk) disable iff (!rst_n)
        serial_out_oe && phase == gei_pkg::PH_SECOND);

endmodule
